// file: logic/call_return_exec_map.svh
// Opcodes, register offsets, widths and reset values for the call, return, timer and carrier executor.
`ifndef CALL_RETURN_EXEC_MAP_SVH
`define CALL_RETURN_EXEC_MAP_SVH

`define WORD_W          9
`define PAGE_W          4
`define LOW_W           7
`define NIB_W           4
`define CTRL3_W         3
`define STACK_DEPTH     8
`define SP_W            3

`define OP_RETURN_PLAIN 9'h044
`define OP_RETURN_SKIP  9'h045
`define OP_TIMER_RD     9'h057
`define OP_TIMER_WR     9'h047
`define OP_TIMER_CTRL   9'h05B
`define OP_TIMER_FLAG   9'h042
`define OP_CARRIER_RD   9'h040
`define OP_CARRIER_WR   9'h05A
`define OP_CARRIER_OUT  9'h086
`define OP_CALL_IDX     9'h050
`define OP_CALL_FAR_PFX 5'h07
`define OP_PAGE_TWO_PFX 2'h2
`define PAGE_TWO        4'h2

`define OP_CMP_IMM      9'h025
`define OP_BR_IDX       9'h001
`define OP_BR_FAR_IDX   9'h010
`define OP_BR_FAR_PFX   5'h03

`define ADDR_STATUS     8'h00
`define ADDR_MASK       8'h04
`define ADDR_CORE       8'h08
`define ADDR_PC         8'h0C
`define ADDR_TIMER      8'h10
`define ADDR_CARRIER    8'h14

`define EV_UNDERFLOW    0
`define EV_STACK_OVER   1
`define EV_STACK_UNDER  2
`define EV_W            3

`define RST_PAGE        4'h0
`define RST_LOW         7'h00
`define RST_NIB         4'h0
`define RST_BYTE        8'h00
`define RST_CTRL3       3'h0
`define RST_EV          3'h0
`define RST_WORD        32'h0000_0000

`endif

// file: logic/call_return_exec_pkg.sv
// Types shared by the executor and its return stack.
`default_nettype none
`include "call_return_exec_map.svh"
package call_return_exec_pkg;
  typedef enum logic [1:0] {ST_FETCH, ST_SECOND, ST_SKIP2, ST_RET} exec_state_t;
  typedef logic [`PAGE_W+`LOW_W-1:0] ret_addr_t;
endpackage
`default_nettype wire

// file: logic/return_stack_if.sv
// Interface between the executor and its return-address stack.
`default_nettype none
`include "call_return_exec_map.svh"
interface return_stack_if;
  import call_return_exec_pkg::*;
  logic              push;
  logic              pop;
  ret_addr_t         push_data;
  ret_addr_t         pop_data;
  logic [`SP_W-1:0]  stack_ptr;
  logic              overflow;
  logic              underflow;
  modport core  (output push, output pop, output push_data,
                 input pop_data, input stack_ptr, input overflow, input underflow);
  modport stack (input push, input pop, input push_data,
                 output pop_data, output stack_ptr, output overflow, output underflow);
endinterface
`default_nettype wire

// file: logic/return_stack.sv
// Fixed-depth return-address stack with a wrapping pointer.
`default_nettype none
`include "call_return_exec_map.svh"
module return_stack
  import call_return_exec_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  return_stack_if.stack sk
);
  ret_addr_t return_stack_mem [`STACK_DEPTH];

  // The pointer wraps in both directions so a runaway program stays deterministic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sk.stack_ptr <= '0;
    end else if (sk.push) begin
      sk.stack_ptr <= sk.stack_ptr + 1'b1;
    end else if (sk.pop) begin
      sk.stack_ptr <= sk.stack_ptr - 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (sk.push) begin
      return_stack_mem[sk.stack_ptr] <= sk.push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sk.pop_data <= '0;
    end else if (sk.pop) begin
      sk.pop_data <= return_stack_mem[sk.stack_ptr - 1'b1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sk.overflow  <= 1'b0;
      sk.underflow <= 1'b0;
    end else begin
      sk.overflow  <= sk.push && (sk.stack_ptr == {`SP_W{1'b1}});
      sk.underflow <= sk.pop && (sk.stack_ptr == '0);
    end
  end
endmodule
`default_nettype wire

// file: logic/call_return_exec.sv
// Executor for subroutine calls, returns, timer 1 and carrier instructions, with an APB register window.
`default_nettype none
`include "call_return_exec_map.svh"

module call_return_exec
  import call_return_exec_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [`WORD_W-1:0]  instr_word,
  input  wire logic                instr_valid,
  output logic                     instr_ready,
  output logic      [`PAGE_W-1:0]  pc_page,
  output logic      [`LOW_W-1:0]   pc_low,
  output logic                     carrier_out_latch,
  output logic                     irq
);
  exec_state_t               state;
  exec_state_t               next_state;
  logic [`WORD_W-1:0]        first_word;
  logic                      skip_next;
  logic [`NIB_W-1:0]         acc;
  logic [`NIB_W-1:0]         b;
  logic [2*`NIB_W-1:0]       timer_count;
  logic [2*`NIB_W-1:0]       timer_reload;
  logic [`CTRL3_W-1:0]       timer_ctrl_reg;
  logic                      timer_underflow_flag;
  logic [`CTRL3_W-1:0]       carrier_ctrl;
  logic [`EV_W-1:0]          status;
  logic [`EV_W-1:0]          mask;
  ret_addr_t                 next_pc;
  ret_addr_t                 pc_inc;
  logic                      take;
  logic                      exec;
  logic                      set_skip;
  logic                      clr_skip;
  logic                      timer_underflow;
  logic                      apb_done;
  logic                      apb_start;
  logic [31:0]               read_mux;
  logic                      unmapped;
  logic [`EV_W-1:0]          events;

  return_stack_if sk ();

  return_stack u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .sk      (sk)
  );

  // First words of every two-word instruction, so a skip can pass over both words.
  function automatic logic is_two_word(input logic [`WORD_W-1:0] w);
    is_two_word = (w[8:4] == `OP_CALL_FAR_PFX) || (w == `OP_CALL_IDX) || (w == `OP_CMP_IMM) ||
                  (w[8:4] == `OP_BR_FAR_PFX) || (w == `OP_BR_IDX) || (w == `OP_BR_FAR_IDX);
  endfunction

  assign take   = instr_valid && instr_ready;
  assign exec   = take && (state == ST_FETCH) && !skip_next;
  assign pc_inc = {pc_page, pc_low} + 1'b1;

  always_comb begin
    next_state   = state;
    next_pc      = {pc_page, pc_low};
    sk.push      = 1'b0;
    sk.pop       = 1'b0;
    sk.push_data = pc_inc;
    set_skip     = 1'b0;
    clr_skip     = 1'b0;
    case (state)
      ST_FETCH: begin
        if (take) begin
          next_pc = pc_inc;
          if (skip_next) begin
            clr_skip = 1'b1;
            if (is_two_word(instr_word)) begin
              next_state = ST_SKIP2;
            end
          end else if (instr_word[8:7] == `OP_PAGE_TWO_PFX) begin
            sk.push = 1'b1;
            next_pc = {`PAGE_TWO, instr_word[`LOW_W-1:0]};
          end else if (instr_word[8:4] == `OP_CALL_FAR_PFX || instr_word == `OP_CALL_IDX) begin
            next_state = ST_SECOND;
          end else if (instr_word == `OP_RETURN_PLAIN || instr_word == `OP_RETURN_SKIP) begin
            sk.pop     = 1'b1;
            next_state = ST_RET;
          end else if (instr_word == `OP_TIMER_FLAG && timer_underflow_flag) begin
            set_skip = 1'b1;
          end
        end
      end
      ST_SECOND: begin
        if (take) begin
          sk.push    = 1'b1;
          next_state = ST_FETCH;
          if (first_word == `OP_CALL_IDX) begin
            next_pc = {instr_word[3:0], instr_word[6:4], acc};
          end else begin
            next_pc = {first_word[3:0], instr_word[`LOW_W-1:0]};
          end
        end
      end
      ST_SKIP2: begin
        if (take) begin
          next_pc    = pc_inc;
          next_state = ST_FETCH;
        end
      end
      ST_RET: begin
        next_pc    = sk.pop_data;
        next_state = ST_FETCH;
        if (first_word == `OP_RETURN_SKIP) begin
          set_skip = 1'b1;
        end
      end
      default: begin
        next_state = ST_FETCH;
      end
    endcase
  end

  // Fetch is held off during the second cycle of a return, while the stack read lands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_FETCH;
      instr_ready <= 1'b0;
      pc_page     <= `RST_PAGE;
      pc_low      <= `RST_LOW;
      first_word  <= '0;
    end else begin
      state       <= next_state;
      instr_ready <= (next_state != ST_RET);
      pc_page     <= next_pc[`PAGE_W+`LOW_W-1:`LOW_W];
      pc_low      <= next_pc[`LOW_W-1:0];
      if (take && state == ST_FETCH) begin
        first_word <= instr_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_next <= 1'b0;
    end else if (set_skip) begin
      skip_next <= 1'b1;
    end else if (clr_skip) begin
      skip_next <= 1'b0;
    end
  end

  // Instruction writes win over a software write to the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= `RST_NIB;
      b   <= `RST_NIB;
    end else if (exec && instr_word == `OP_TIMER_RD) begin
      b   <= timer_count[2*`NIB_W-1:`NIB_W];
      acc <= timer_count[`NIB_W-1:0];
    end else if (exec && instr_word == `OP_CARRIER_RD) begin
      acc[`CTRL3_W-1:0] <= carrier_ctrl;
    end else if (apb_done && pwrite && paddr == `ADDR_CORE) begin
      acc <= pwdata[`NIB_W-1:0];
      b   <= pwdata[2*`NIB_W-1:`NIB_W];
    end
  end

  assign timer_underflow = timer_ctrl_reg[0] && (timer_count == '0);

  // The timer counts down once per clock while running and reloads on underflow.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count  <= `RST_BYTE;
      timer_reload <= `RST_BYTE;
    end else begin
      if (exec && instr_word == `OP_TIMER_WR) begin
        timer_reload <= {b, acc};
      end
      if (exec && instr_word == `OP_TIMER_WR && !timer_ctrl_reg[0]) begin
        timer_count <= {b, acc};
      end else if (timer_underflow) begin
        timer_count <= timer_reload;
      end else if (timer_ctrl_reg[0]) begin
        timer_count <= timer_count - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctrl_reg <= `RST_CTRL3;
    end else if (exec && instr_word == `OP_TIMER_CTRL) begin
      timer_ctrl_reg <= acc[`CTRL3_W-1:0];
    end
  end

  // A fresh underflow in the clearing cycle keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_underflow_flag <= 1'b0;
    end else if (timer_underflow) begin
      timer_underflow_flag <= 1'b1;
    end else if (exec && instr_word == `OP_TIMER_FLAG) begin
      timer_underflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_ctrl      <= `RST_CTRL3;
      carrier_out_latch <= 1'b0;
    end else if (exec && instr_word == `OP_CARRIER_WR) begin
      carrier_ctrl      <= acc[`CTRL3_W-1:0];
      carrier_out_latch <= 1'b0;
    end else if (exec && instr_word == `OP_CARRIER_OUT) begin
      carrier_out_latch <= acc[`NIB_W-1];
    end
  end

  assign apb_start = psel && penable && !pready;
  assign apb_done  = psel && penable && pready;

  always_comb begin
    read_mux = `RST_WORD;
    unmapped = 1'b0;
    if (paddr == `ADDR_STATUS) begin
      read_mux[`EV_W-1:0] = status;
    end else if (paddr == `ADDR_MASK) begin
      read_mux[`EV_W-1:0] = mask;
    end else if (paddr == `ADDR_CORE) begin
      read_mux[2*`NIB_W-1:0] = {b, acc};
    end else if (paddr == `ADDR_PC) begin
      read_mux[`SP_W+`PAGE_W+`LOW_W-1:0] = {sk.stack_ptr, pc_page, pc_low};
    end else if (paddr == `ADDR_TIMER) begin
      read_mux[`CTRL3_W+4*`NIB_W:0] = {timer_underflow_flag, timer_ctrl_reg, timer_reload, timer_count};
    end else if (paddr == `ADDR_CARRIER) begin
      read_mux[`CTRL3_W:0] = {carrier_out_latch, carrier_ctrl};
    end else begin
      unmapped = 1'b1;
    end
  end

  // The answer is registered, so every access spends exactly one wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_start;
      pslverr <= apb_start && unmapped;
      if (apb_start) begin
        prdata <= pwrite ? `RST_WORD : read_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= `RST_EV;
    end else if (apb_done && pwrite && paddr == `ADDR_MASK) begin
      mask <= pwdata[`EV_W-1:0];
    end
  end

  assign events = {sk.underflow, sk.overflow, timer_underflow};

  // A read clears only the bits it reported, so an event after the sample is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `RST_EV;
    end else if (apb_done && !pwrite && paddr == `ADDR_STATUS) begin
      status <= (status & ~prdata[`EV_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end
endmodule
`default_nettype wire

// file: dv/call_return_exec_checker.sv
// Concurrent checks on the executor's instruction stream, carrier output and APB answer.
`default_nettype none
`include "call_return_exec_map.svh"
module call_return_exec_checker (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [`WORD_W-1:0] instr_word,
  input wire logic               instr_valid,
  input wire logic               instr_ready,
  input wire logic [`PAGE_W-1:0] pc_page,
  input wire logic [`LOW_W-1:0]  pc_low,
  input wire logic               carrier_out_latch,
  input wire logic               irq
);
  logic        norm;
  wire logic   take = instr_valid && instr_ready;
  wire logic   fire = take && norm;
  wire logic [10:0] pc_all = {pc_page, pc_low};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A word after a skip source or a pair opener may be skipped or a second word, so it is not judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      norm <= 1'b1;
    end else if (take) begin
      norm <= !(instr_word[8:4] == `OP_CALL_FAR_PFX || instr_word[8:4] == `OP_BR_FAR_PFX
                || instr_word == `OP_CALL_IDX || instr_word == `OP_CMP_IMM || instr_word == `OP_BR_IDX
                || instr_word == `OP_BR_FAR_IDX || instr_word == `OP_RETURN_SKIP || instr_word == `OP_TIMER_FLAG);
    end
  end
  a_page_two_jump: assert property (
    fire && instr_word[8:7] == `OP_PAGE_TWO_PFX |=> pc_page == `PAGE_TWO && pc_low == $past(instr_word[6:0]))
    else $error("page-two call went to the wrong place");
  a_far_jump: assert property (
    fire && instr_word[8:4] == `OP_CALL_FAR_PFX ##1 take
    |=> pc_page == $past(instr_word[3:0], 2) && pc_low == $past(instr_word[6:0]))
    else $error("far call went to the wrong place");
  a_idx_jump: assert property (
    fire && instr_word == `OP_CALL_IDX ##1 take
    |=> pc_page == $past(instr_word[3:0]) && pc_low[6:4] == $past(instr_word[6:4]))
    else $error("indexed call went to the wrong place");
  a_ret_bubble: assert property (
    fire && (instr_word == `OP_RETURN_PLAIN || instr_word == `OP_RETURN_SKIP) |=> !instr_ready ##1 instr_ready)
    else $error("return did not take two cycles");
  a_no_stray_stall: assert property (
    !instr_ready && $past(presetn)
    |-> $past(take) && ($past(instr_word) == `OP_RETURN_PLAIN || $past(instr_word) == `OP_RETURN_SKIP))
    else $error("fetch stalled without a return");
  a_carrier_clear: assert property (
    fire && instr_word == `OP_CARRIER_WR |=> !carrier_out_latch)
    else $error("carrier write left the latch set");
  a_latch_cause: assert property (
    $changed(carrier_out_latch)
    |-> $past(take) && ($past(instr_word) == `OP_CARRIER_OUT || $past(instr_word) == `OP_CARRIER_WR))
    else $error("carrier latch moved without a carrier instruction");
  a_pc_step: assert property (
    fire && instr_word == `OP_CARRIER_OUT |=> pc_all == $past(pc_all) + 11'h001)
    else $error("carrier output did not step the program counter");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
endmodule
bind call_return_exec call_return_exec_checker u_call_return_exec_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_word(instr_word),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .pc_page(pc_page), .pc_low(pc_low),
  .carrier_out_latch(carrier_out_latch), .irq(irq));
`default_nettype wire

// file: dv/instr_rom.sv
// Program memory that answers the executor's fetches at the current program counter.
`default_nettype none
`include "call_return_exec_map.svh"
module instr_rom (
  input  wire logic [`PAGE_W-1:0] pc_page,
  input  wire logic [`LOW_W-1:0]  pc_low,
  input  wire logic [10:0]        stop_addr,
  input  wire logic               run,
  output logic      [`WORD_W-1:0] instr_word,
  output logic                    instr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`WORD_W-1:0] mem [0:2047];
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = '0;
    end
  end
  // Fetch stalls at the stop address so the bench can inspect state between program phases.
  assign instr_valid = run && ({pc_page, pc_low} != stop_addr);
  // A stalled fetch shows the inverted word, so a stale value is never mistaken for a fresh one.
  assign instr_word = instr_valid ? mem[{pc_page, pc_low}] : ~mem[{pc_page, pc_low}];
endmodule
`default_nettype wire

// file: dv/tb.sv
// Directed bench for the call, return, timer and carrier executor and its APB window.
`default_nettype none
`include "call_return_exec_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, instr_valid, instr_ready;
  logic        carrier_out_latch, irq, run, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [8:0]  instr_word;
  logic [3:0]  pc_page;
  logic [6:0]  pc_low;
  logic [10:0] stop_addr;
  int          err_total = 0;
  int          checks_done = 0;
  // Upper half is the word address, lower half the instruction word.
  localparam logic [31:0] PROG [27] = '{
    32'h0000_005A, 32'h0001_0086, 32'h0002_0047, 32'h0003_0110, 32'h0110_0045, 32'h0004_0074, 32'h0005_0120,
    32'h0006_0073, 32'h0007_0105, 32'h0185_0050, 32'h0186_0126, 32'h032C_0044, 32'h0187_0044, 32'h0008_0040,
    32'h0009_0057, 32'h000A_005B, 32'h000B_0047, 32'h000C_0042, 32'h000D_005A, 32'h000E_0101, 32'h0101_0102,
    32'h0102_0103, 32'h0103_0104, 32'h0104_0105, 32'h0105_0106, 32'h0106_0107, 32'h0107_0108};
  always #2 pclk = ~pclk;
  call_return_exec u_call_return_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready), .pc_page(pc_page),
    .pc_low(pc_low), .carrier_out_latch(carrier_out_latch), .irq(irq));
  instr_rom u_instr_rom (.pc_page(pc_page), .pc_low(pc_low), .stop_addr(stop_addr), .run(run),
    .instr_word(instr_word), .instr_valid(instr_valid));
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat & m, e);
  endtask
  // The stop address is where the fetch stalls; the loop waits for the program to get there.
  task automatic run_to(input logic [10:0] a);
    stop_addr <= a;
    run <= 1'b1;
    for (int i = 0; i < 300 && {pc_page, pc_low} !== a; i++) @(posedge pclk);
    if ({pc_page, pc_low} !== a) begin
      err_total++;
      $display("unexpected at %0t: program did not reach %h", $time, a);
    end
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    run = 1'b0;
    stop_addr = 11'h000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (PROG[i]) u_instr_rom.mem[PROG[i][26:16]] = PROG[i][8:0];
    for (int a = 0; a <= 20; a += 4) begin
      rd(8'(a), 32'hFFFF_FFFF, 32'h0000_0000);
    end
    rd(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    apb(1'b1, `ADDR_PC, 32'hFFFF_FFFF);
    rd(`ADDR_PC, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, `ADDR_CORE, 32'h0000_005C);
    rd(`ADDR_CORE, 32'hFFFF_FFFF, 32'h0000_005C);
    run_to(11'h008);
    rd(`ADDR_PC, 32'hFFFF_FFFF, 32'h0000_0008);
    rd(`ADDR_CARRIER, 32'hFFFF_FFFF, 32'h0000_000C);
    rd(`ADDR_TIMER, 32'hFFFF_FFFF, 32'h0000_5C5C);
    chk(32'(carrier_out_latch), 32'h0000_0001);
    apb(1'b1, `ADDR_CORE, 32'h0000_0000);
    run_to(11'h009);
    rd(`ADDR_CORE, 32'hFFFF_FFFF, 32'h0000_0004);
    run_to(11'h00A);
    rd(`ADDR_CORE, 32'hFFFF_FFFF, 32'h0000_005C);
    apb(1'b1, `ADDR_CORE, 32'h0000_0001);
    run_to(11'h00C);
    repeat (150) @(posedge pclk);
    rd(`ADDR_TIMER, 32'h0007_FF00, 32'h0001_0100);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, `ADDR_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0000_0001);
    rd(`ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, `ADDR_MASK, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0000_0000);
    run_to(11'h00E);
    rd(`ADDR_CARRIER, 32'hFFFF_FFFF, 32'h0000_000C);
    run_to(11'h108);
    rd(`ADDR_PC, 32'hFFFF_FFFF, 32'h0000_0108);
    rd(`ADDR_STATUS, 32'h0000_0006, 32'h0000_0002);
    print_verdict();
  end
endmodule
`default_nettype wire
